// File: dv/pmc_props.sv
`timescale 1ns/10ps
module pmc_props
  import pmc_pkg::*;
#(
  parameter int N_PER = 16,
  parameter int PRIO_W = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sleep_req,
  input wire logic deep_sleep,
  input wire logic mode_sel,
  input wire logic ram_exec,
  input wire logic [3:0] mode,
  input wire logic core_halt,
  input wire logic wake
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // run code lags the ram fetch bit by one cycle
  chk_run_mode: assert property (!core_halt |-> mode == ($past(ram_exec) ? MODE_PM1 : MODE_PM0))
    else $error("run mode code wrong");
  chk_enter_light: assert property (sleep_req && !core_halt && !deep_sleep |=>
    core_halt && mode == MODE_PM2)
    else $error("light sleep not entered");
  chk_enter_deep: assert property (sleep_req && !core_halt && deep_sleep && !mode_sel |=>
    mode == MODE_PM3)
    else $error("deep sleep not entered");
  chk_enter_off: assert property (sleep_req && !core_halt && deep_sleep && mode_sel |=>
    mode == MODE_PM9)
    else $error("off mode not entered");
  chk_halt_codes: assert property (core_halt == (mode == MODE_PM2 || mode == MODE_PM3 ||
    mode == MODE_PM9))
    else $error("halt and mode disagree");
  chk_wake_exit: assert property (wake |-> !core_halt && $past(core_halt))
    else $error("wake without leaving halt");
  chk_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  chk_halt_leave: assert property ($fell(core_halt) |-> wake || $past(mode) == MODE_PM9)
    else $error("halt left without wake");
  chk_off_nowake: assert property (wake |-> $past(mode) != MODE_PM9)
    else $error("off mode left by wake");

  cov_off: cover property (sleep_req && deep_sleep && mode_sel);
  cov_deep_wake: cover property (wake && $past(mode) == MODE_PM3);
  cov_ram_run: cover property (mode == MODE_PM1);
endmodule : pmc_props

// File: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import pmc_pkg::*;
;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, er, m_woke, f;
  logic [7:0] paddr, irq_pend;
  logic [31:0] pwdata, prdata, rd, m_gate;
  logic [23:0] irq_prio;
  logic [6:0] wake_src, pmu_reset_src;
  logic ahb_clk_en, apb_clk_en, fetch_from_ram, lposc_run, lposc_suspend, slow_osc_run;
  logic sys_clk_on_lposc, pins_low_power, std_ram_power, ret_ram_power, pm9_reset_req;
  logic [15:0] periph_clk_en;
  logic [8:0] pw;
  int n_fail, n_checks, c, s;
  assign pw = {ahb_clk_en, apb_clk_en, lposc_run, lposc_suspend, slow_osc_run,
    sys_clk_on_lposc, pins_low_power, std_ram_power, ret_ram_power};

  pmc_link_if lnk ();
  pmc_core_end pmc_core_end_i (.clk_sys(clk_sys), .rst(rst),
    .lnk(lnk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pmc_power_ctrl pmc_power_ctrl_i (.clk_sys(clk_sys),
    .rst(rst), .lnk(lnk), .irq_pend(irq_pend), .irq_prio(irq_prio), .wake_src(wake_src),
    .pmu_reset_src(pmu_reset_src), .ahb_clk_en(ahb_clk_en), .apb_clk_en(apb_clk_en),
    .periph_clk_en(periph_clk_en), .fetch_from_ram(fetch_from_ram), .lposc_run(lposc_run),
    .lposc_suspend(lposc_suspend), .slow_osc_run(slow_osc_run),
    .sys_clk_on_lposc(sys_clk_on_lposc), .pins_low_power(pins_low_power),
    .std_ram_power(std_ram_power), .ret_ram_power(ret_ram_power),
    .pm9_reset_req(pm9_reset_req));
  pmc_props pmc_props_i (.clk_sys(clk_sys), .rst(rst),
    .sleep_req(lnk.sleep_req), .deep_sleep(lnk.deep_sleep), .mode_sel(lnk.mode_sel),
    .ram_exec(lnk.ram_exec), .mode(lnk.mode), .core_halt(lnk.core_halt), .wake(lnk.wake));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // request held until pready is seen, released only at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    // slave answers in the first access cycle, sampled at the rising edge
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    chk(k, 1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk(er, a > OFS_STAT);
  endtask : rdc

  function automatic logic [31:0] stat(input logic h, input logic [3:0] m);
    return {23'h0, m_woke, 3'h0, h, m};
  endfunction : stat

  task automatic nap(input logic [3:0] m);
    apb(1'b1, OFS_CMD, 32'h1);
    rdc(OFS_STAT, stat(1'b1, m));
  endtask : nap

  // pm9 oscillator bits are left unchecked, so only power, pin and clock bits count there
  task automatic chkp(input int m, input logic fw);
    if (m == 9)
      chk(pw & 9'h187, 9'h005);
    else
      chk(pw, (m == 3) ? {4'b0001, fw, 4'b0011} : {4'b1110, fw, 4'b1011});
  endtask : chkp

  // wake seen at the nth falling edge after the cause lands, 0 means never within 8
  task automatic stim(input logic [7:0] ip, input logic [2:0] pr, input logic [6:0] ws,
    input logic [6:0] rs, input logic p9, input int n);
    int k, got;
    @(posedge clk_sys);
    irq_pend <= ip;
    irq_prio <= {21'h0, pr};
    wake_src <= ws;
    pmu_reset_src <= rs;
    got = 0;
    for (k = 1; k <= 8; k++) begin
      @(negedge clk_sys);
      if (got == 0 && (p9 ? pm9_reset_req : lnk.wake) === 1'b1)
        got = k;
    end
    chk(got, n);
    if (n != 0 && !p9)
      m_woke = 1'b1;
  endtask : stim

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {irq_pend, irq_prio, wake_src, pmu_reset_src} = '0;
    n_fail = 0;
    n_checks = 0;
    m_woke = 1'b0;
    rst = 1'b1;
    c = $urandom(77179);
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chkp(0, 1'b0);
    chk(fetch_from_ram, 1'b0);
    chk(periph_clk_en, 16'hFFFF);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_WAKE, 32'h0);
    rdc(OFS_GATE, 32'hFFFF);
    rdc(OFS_STAT, stat(1'b0, MODE_PM0));
    rdc(8'h14, 32'h0);
    m_gate = {16'h0, 16'($urandom)};
    apb(1'b1, OFS_GATE, m_gate);
    rdc(OFS_GATE, m_gate);
    chk(periph_clk_en, m_gate);
    apb(1'b1, OFS_CTRL, 32'h4);
    rdc(OFS_STAT, stat(1'b0, MODE_PM1));
    chk(fetch_from_ram, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_WAKE, 32'hFFFFFFFF);
    rdc(OFS_WAKE, 32'h7F7F);
    nap(MODE_PM2);
    chkp(2, 1'b0);
    chk(periph_clk_en, m_gate);
    stim(8'h01, 3'h0, 7'h0, 7'h0, 1'b0, 2);
    for (s = 5; s < 7; s++) begin
      stim(8'h0, 3'h0, 7'h0, 7'h0, 1'b0, 0);
      nap(MODE_PM2);
      stim(8'h0, 3'h0, 7'(1 << s), 7'h0, 1'b0, 2);
    end
    c = 1 + $urandom % 7;
    stim(8'h0, 3'h0, 7'h0, 7'h0, 1'b0, 0);
    apb(1'b1, OFS_CTRL, 32'h10 | 32'(c << 8));
    nap(MODE_PM2);
    stim(8'h01, 3'(c), 7'h0, 7'h0, 1'b0, 0);
    stim(8'h01, 3'(c - 1), 7'h0, 7'h0, 1'b0, 2);
    for (s = 0; s < 5; s++) begin
      f = 1'($urandom);
      stim(8'h0, 3'h0, 7'h0, 7'h0, 1'b0, 0);
      apb(1'b1, OFS_CTRL, {28'h0, f, 3'b001});
      nap(MODE_PM3);
      chkp(3, f);
      chk(periph_clk_en, 16'h0000);
      stim(8'hFF, 3'h0, 7'h60, 7'h0, 1'b0, 0);
      stim(8'h0, 3'h0, 7'(1 << s), 7'h0, 1'b0, 2);
      chkp(0, f);
    end
    stim(8'h0, 3'h0, 7'h0, 7'h0, 1'b0, 0);
    apb(1'b1, OFS_CTRL, 32'h3);
    nap(MODE_PM9);
    chkp(9, 1'b0);
    stim(8'hFF, 3'h0, 7'h7F, 7'h0, 1'b0, 0);
    stim(8'h0, 3'h0, 7'h0, 7'(1 << ($urandom % 7)), 1'b1, 2);
    chk(lnk.mode, MODE_PM0);
    chkp(0, 1'b0);
    apb(1'b1, OFS_STAT, 32'h100);
    m_woke = 1'b0;
    rdc(OFS_STAT, stat(1'b0, MODE_PM0));
    wrap_up();
  end

  // whole run is well under a thousand cycles
  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end
endmodule : tb_top

// File: hdl/pmc_core_end.sv
`timescale 1ns/10ps
module pmc_core_end
  import pmc_pkg::*;
#(
  parameter int N_PER = 16,
  parameter int PRIO_W = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  pmc_link_if.core lnk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  if (PRIO_W < 1 || PRIO_W > PRIO_FIELD_W || N_PER < 1 || N_PER > 32) begin : g_bad_param
    $error("pmc_core_end: unsupported parameters");
  end

  typedef struct packed {
    logic deep;
    logic sel;
    logic ram;
    logic fast;
    logic isr;
    logic [PRIO_W-1:0] cprio;
    logic [PRIO_W-1:0] wprio;
    logic [NUM_WAKE-1:0] wake_en;
    logic [NUM_WAKE-1:0] rst_en;
    logic [N_PER-1:0] gate;
    logic sleep;
    logic woke;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } pmc_core_t;

  localparam pmc_core_t RST_VAL = '{
    deep: RST_CTRL_BIT, sel: RST_CTRL_BIT, ram: RST_CTRL_BIT, fast: RST_CTRL_BIT,
    isr: RST_CTRL_BIT, cprio: RST_PRIO[PRIO_W-1:0], wprio: RST_PRIO[PRIO_W-1:0],
    wake_en: RST_WAKE_EN, rst_en: RST_RST_EN, gate: {N_PER{RST_GATE_BIT}},
    sleep: 1'b0, woke: 1'b0, rdata: 32'h0000_0000, ready: 1'b0, err: 1'b0
  };

  pmc_core_t cur_ff;
  pmc_core_t nxt_ff;

  always_comb begin
    logic setup;
    logic wr;
    setup = psel && !penable;
    wr = psel && penable && cur_ff.ready && pwrite;
    nxt_ff = cur_ff;
    nxt_ff.sleep = 1'b0;
    nxt_ff.ready = setup;
    nxt_ff.err = 1'b0;
    // read data is captured in the setup cycle, so every access takes two cycles
    if (setup) begin
      nxt_ff.rdata = 32'h0000_0000;
      if (paddr == OFS_CTRL) begin
        nxt_ff.rdata[CTRL_DEEP] = cur_ff.deep;
        nxt_ff.rdata[CTRL_SEL] = cur_ff.sel;
        nxt_ff.rdata[CTRL_RAM] = cur_ff.ram;
        nxt_ff.rdata[CTRL_FAST] = cur_ff.fast;
        nxt_ff.rdata[CTRL_ISR] = cur_ff.isr;
        nxt_ff.rdata[CTRL_CPRIO +: PRIO_W] = cur_ff.cprio;
        nxt_ff.rdata[CTRL_WPRIO +: PRIO_W] = cur_ff.wprio;
      end else if (paddr == OFS_WAKE) begin
        nxt_ff.rdata[WAKE_EN_LSB +: NUM_WAKE] = cur_ff.wake_en;
        nxt_ff.rdata[RST_EN_LSB +: NUM_WAKE] = cur_ff.rst_en;
      end else if (paddr == OFS_GATE) begin
        nxt_ff.rdata[N_PER-1:0] = cur_ff.gate;
      end else if (paddr == OFS_CMD) begin
        nxt_ff.rdata = 32'h0000_0000;
      end else if (paddr == OFS_STAT) begin
        nxt_ff.rdata[STAT_MODE +: 4] = lnk.mode;
        nxt_ff.rdata[STAT_HALT] = lnk.core_halt;
        nxt_ff.rdata[STAT_WOKE] = cur_ff.woke;
      end else begin
        nxt_ff.err = 1'b1;
      end
    end
    if (wr) begin
      if (paddr == OFS_CTRL) begin
        nxt_ff.deep = pwdata[CTRL_DEEP]; // [R15]
        nxt_ff.sel = pwdata[CTRL_SEL]; // [R15]
        nxt_ff.ram = pwdata[CTRL_RAM];
        nxt_ff.fast = pwdata[CTRL_FAST];
        nxt_ff.isr = pwdata[CTRL_ISR];
        nxt_ff.cprio = pwdata[CTRL_CPRIO +: PRIO_W];
        nxt_ff.wprio = pwdata[CTRL_WPRIO +: PRIO_W];
      end else if (paddr == OFS_WAKE) begin
        nxt_ff.wake_en = pwdata[WAKE_EN_LSB +: NUM_WAKE];
        nxt_ff.rst_en = pwdata[RST_EN_LSB +: NUM_WAKE]; // [R16]
      end else if (paddr == OFS_GATE) begin
        nxt_ff.gate = pwdata[N_PER-1:0];
      end else if (paddr == OFS_CMD) begin
        // issued only after the write has completed on the bus
        nxt_ff.sleep = pwdata[CMD_SLEEP] && !lnk.core_halt; // [R4] [R17]
      end else if (paddr == OFS_STAT) begin
        if (pwdata[STAT_WOKE]) begin
          nxt_ff.woke = 1'b0;
        end
      end
    end
    // set after clear so a wake in the clearing cycle survives
    if (lnk.wake) begin
      nxt_ff.woke = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_ff <= RST_VAL;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign lnk.sleep_req = cur_ff.sleep;
  assign lnk.deep_sleep = cur_ff.deep;
  assign lnk.mode_sel = cur_ff.sel;
  assign lnk.ram_exec = cur_ff.ram;
  assign lnk.fast_wake = cur_ff.fast;
  assign lnk.in_isr = cur_ff.isr;
  assign lnk.cur_prio = cur_ff.cprio;
  assign lnk.wake_prio = cur_ff.wprio;
  assign lnk.wake_en = cur_ff.wake_en;
  assign lnk.rst_en = cur_ff.rst_en;
  assign lnk.clk_gate = cur_ff.gate;
  assign prdata = cur_ff.rdata;
  assign pready = cur_ff.ready;
  assign pslverr = cur_ff.err;
endmodule : pmc_core_end

// File: hdl/pmc_power_ctrl.sv
`timescale 1ns/10ps
// Function
// [R1] reset lands in normal mode, flash fetch
// [R2] mode 1 runs fully, fetching from RAM
// [R3] mode 2 halts core, enabled peripherals run
// [R4] core enters sleep by a sleep request
// [R5] inside handler only preempting interrupts wake
// [R6] mode 2 wakes on bus clocked interrupts
// [R7] mode 3 stops memory and peripheral clocks
// [R8] mode 3 wakes only on clockless sources
// [R9] fast wake idles slow, resumes fast oscillator
// [R10] mode 3 suspends the low power oscillator
// [R11] sleep with deep bit enters mode 3
// [R12] mode 9 stops everything, pins low power
// [R13] mode 9 keeps retention RAM only
// [R14] mode 9 left only by enabled reset
// [R15] software sets deep and select bits first
// [R16] software enables reset sources before mode 9
// [R17] bus accesses finish before sleep request
// [R18] accepts timer, alarm, comparator, pin wakes
// [R19] each peripheral clock individually gated
// [R20] deep and select gives 9, deep 3
module pmc_power_ctrl
  import pmc_pkg::*;
#(
  parameter int N_PER = 16,
  parameter int N_IRQ = 8,
  parameter int PRIO_W = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  pmc_link_if.pmc lnk,
  input wire logic [N_IRQ-1:0] irq_pend,
  input wire logic [N_IRQ*PRIO_W-1:0] irq_prio,
  input wire logic [NUM_WAKE-1:0] wake_src,
  input wire logic [NUM_WAKE-1:0] pmu_reset_src,
  output logic ahb_clk_en,
  output logic apb_clk_en,
  output logic [N_PER-1:0] periph_clk_en,
  output logic fetch_from_ram,
  output logic lposc_run,
  output logic lposc_suspend,
  output logic slow_osc_run,
  output logic sys_clk_on_lposc,
  output logic pins_low_power,
  output logic std_ram_power,
  output logic ret_ram_power,
  output logic pm9_reset_req
);
  if (N_PER < 1 || N_PER > 32 || N_IRQ < 1 || PRIO_W < 1 || PRIO_W > PRIO_FIELD_W)
  begin : g_bad_param
    $error("pmc_power_ctrl: unsupported parameters");
  end

  typedef struct packed {
    pmc_state_t state;
    logic [3:0] mode;
    logic halt;
    logic wake;
    logic ahb;
    logic apb;
    logic [N_PER-1:0] gate;
    logic ram_fetch;
    logic lposc_run;
    logic lposc_susp;
    logic slow_run;
    logic on_lposc;
    logic pins_lp;
    logic std_ram;
    logic ret_ram;
    logic rst_req;
  } pmc_dev_t;

  localparam pmc_dev_t RST_VAL = '{
    state: ST_RUN,
    mode: MODE_PM0,
    halt: 1'b0,
    wake: 1'b0,
    ahb: 1'b1,
    apb: 1'b1,
    gate: {N_PER{RST_GATE_BIT}},
    ram_fetch: 1'b0,
    lposc_run: 1'b1,
    lposc_susp: 1'b0,
    slow_run: 1'b0,
    on_lposc: 1'b1,
    pins_lp: 1'b0,
    std_ram: 1'b1,
    ret_ram: 1'b1,
    rst_req: 1'b0
  };

  pmc_dev_t cur_ff;
  pmc_dev_t nxt_ff;
  logic wake_hit;

  pmc_wake_qual #(
    .N_IRQ(N_IRQ),
    .PRIO_W(PRIO_W)
  ) u_qual (
    .in_pm3(cur_ff.state == ST_PM3),
    .in_isr(lnk.in_isr),
    .cur_prio(lnk.cur_prio),
    .wake_prio(lnk.wake_prio),
    .irq_pend(irq_pend),
    .irq_prio(irq_prio),
    .wake_src(wake_src),
    .wake_en(lnk.wake_en),
    .wake(wake_hit)
  );

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.wake = 1'b0;
    nxt_ff.rst_req = 1'b0;

    case (cur_ff.state)
      ST_RUN: begin
        if (lnk.sleep_req) begin // [R4]
          if (lnk.deep_sleep && lnk.mode_sel) begin
            nxt_ff.state = ST_PM9; // [R20] [R14]
          end else if (lnk.deep_sleep) begin
            nxt_ff.state = ST_PM3; // [R20] [R11]
          end else begin
            nxt_ff.state = ST_PM2; // [R20]
          end
        end
      end
      ST_PM2: begin
        if (wake_hit) begin // [R6] [R5]
          nxt_ff.state = ST_RUN;
          nxt_ff.wake = 1'b1;
        end
      end
      ST_PM3: begin
        if (wake_hit) begin // [R8]
          nxt_ff.state = ST_RUN;
          nxt_ff.wake = 1'b1;
        end
      end
      ST_PM9: begin
        // interrupts and wake pins are ignored here; only a reset ends it
        if (|(pmu_reset_src & lnk.rst_en)) begin // [R14]
          nxt_ff.state = ST_RUN;
          nxt_ff.rst_req = 1'b1;
        end
      end
      default: begin
        nxt_ff.state = ST_RUN;
      end
    endcase

    // outputs follow the next state so they stay registered with it
    case (nxt_ff.state)
      ST_RUN: begin
        nxt_ff.mode = lnk.ram_exec ? MODE_PM1 : MODE_PM0; // [R1] [R2]
        nxt_ff.halt = 1'b0;
        nxt_ff.ahb = 1'b1;
        nxt_ff.apb = 1'b1;
        nxt_ff.gate = lnk.clk_gate; // [R19]
        nxt_ff.ram_fetch = lnk.ram_exec; // [R2]
        nxt_ff.lposc_run = 1'b1; // [R9]
        nxt_ff.lposc_susp = 1'b0;
        nxt_ff.slow_run = lnk.fast_wake;
        nxt_ff.on_lposc = 1'b1; // [R9]
        nxt_ff.pins_lp = 1'b0;
        nxt_ff.std_ram = 1'b1;
        nxt_ff.ret_ram = 1'b1;
      end
      ST_PM2: begin
        nxt_ff.mode = MODE_PM2;
        nxt_ff.halt = 1'b1; // [R3]
        nxt_ff.ahb = 1'b1;
        nxt_ff.apb = 1'b1;
        nxt_ff.gate = lnk.clk_gate; // [R3] [R19]
        nxt_ff.lposc_run = 1'b1;
        nxt_ff.lposc_susp = 1'b0;
        nxt_ff.on_lposc = 1'b1;
        nxt_ff.pins_lp = 1'b0;
        nxt_ff.std_ram = 1'b1;
        nxt_ff.ret_ram = 1'b1;
      end
      ST_PM3: begin
        nxt_ff.mode = MODE_PM3;
        nxt_ff.halt = 1'b1;
        nxt_ff.ahb = 1'b0; // [R7]
        nxt_ff.apb = 1'b0; // [R7]
        nxt_ff.gate = {N_PER{1'b0}}; // [R7]
        nxt_ff.lposc_run = 1'b0; // [R10]
        nxt_ff.lposc_susp = 1'b1; // [R10]
        // fast wake keeps the slow clock ticking for a quick restart
        nxt_ff.slow_run = lnk.fast_wake; // [R9]
        nxt_ff.on_lposc = 1'b0; // [R9]
        nxt_ff.pins_lp = 1'b0;
        nxt_ff.std_ram = 1'b1;
        nxt_ff.ret_ram = 1'b1;
      end
      ST_PM9: begin
        nxt_ff.mode = MODE_PM9;
        nxt_ff.halt = 1'b1; // [R12]
        nxt_ff.ahb = 1'b0; // [R12]
        nxt_ff.apb = 1'b0;
        nxt_ff.gate = {N_PER{1'b0}};
        nxt_ff.lposc_run = 1'b0;
        nxt_ff.lposc_susp = 1'b1;
        nxt_ff.slow_run = 1'b0; // [R12]
        nxt_ff.on_lposc = 1'b0;
        nxt_ff.pins_lp = 1'b1; // [R12]
        nxt_ff.std_ram = 1'b0; // [R13]
        nxt_ff.ret_ram = 1'b1; // [R13]
      end
      default: begin
        nxt_ff.mode = MODE_PM0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_ff <= RST_VAL; // [R1]
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign lnk.mode = cur_ff.mode;
  assign lnk.core_halt = cur_ff.halt;
  assign lnk.wake = cur_ff.wake;
  assign ahb_clk_en = cur_ff.ahb;
  assign apb_clk_en = cur_ff.apb;
  assign periph_clk_en = cur_ff.gate;
  assign fetch_from_ram = cur_ff.ram_fetch;
  assign lposc_run = cur_ff.lposc_run;
  assign lposc_suspend = cur_ff.lposc_susp;
  assign slow_osc_run = cur_ff.slow_run;
  assign sys_clk_on_lposc = cur_ff.on_lposc;
  assign pins_low_power = cur_ff.pins_lp;
  assign std_ram_power = cur_ff.std_ram;
  assign ret_ram_power = cur_ff.ret_ram;
  assign pm9_reset_req = cur_ff.rst_req;
endmodule : pmc_power_ctrl

// File: hdl/pmc_wake_qual.sv
`timescale 1ns/10ps
module pmc_wake_qual
  import pmc_pkg::*;
#(
  parameter int N_IRQ = 8,
  parameter int PRIO_W = 3
) (
  input wire logic in_pm3,
  input wire logic in_isr,
  input wire logic [PRIO_W-1:0] cur_prio,
  input wire logic [PRIO_W-1:0] wake_prio,
  input wire logic [N_IRQ-1:0] irq_pend,
  input wire logic [N_IRQ*PRIO_W-1:0] irq_prio,
  input wire logic [NUM_WAKE-1:0] wake_src,
  input wire logic [NUM_WAKE-1:0] wake_en,
  output logic wake
);
  logic [N_IRQ-1:0] irq_ok;
  logic [NUM_WAKE-1:0] src_ok;
  logic src_prio_ok;

  // lower number is more urgent; inside a handler only preempting levels count
  genvar gi;
  generate
    for (gi = 0; gi < N_IRQ; gi++) begin : g_irq
      assign irq_ok[gi] = irq_pend[gi] &
        (!in_isr || (irq_prio[gi*PRIO_W +: PRIO_W] < cur_prio)); // [R5] [R6]
    end
  endgenerate

  assign src_prio_ok = !in_isr || (wake_prio < cur_prio); // [R5]
  // bus clocked interrupts are dead while the bus clocks are stopped
  assign src_ok = wake_src & wake_en & (in_pm3 ? PM3_WAKE_MASK : {NUM_WAKE{1'b1}}); // [R8] [R18]
  assign wake = ((|src_ok) && src_prio_ok) || (!in_pm3 && (|irq_ok)); // [R6]
endmodule : pmc_wake_qual

// File: include/pmc_link_if.sv
`timescale 1ns/10ps
interface pmc_link_if #(
  parameter int N_PER = 16,
  parameter int PRIO_W = 3
);
  import pmc_pkg::*;
  logic sleep_req;
  logic deep_sleep;
  logic mode_sel;
  logic ram_exec;
  logic fast_wake;
  logic in_isr;
  logic [PRIO_W-1:0] cur_prio;
  logic [PRIO_W-1:0] wake_prio;
  logic [NUM_WAKE-1:0] wake_en;
  logic [NUM_WAKE-1:0] rst_en;
  logic [N_PER-1:0] clk_gate;
  logic [3:0] mode;
  logic core_halt;
  logic wake;

  modport core (
    output sleep_req, deep_sleep, mode_sel, ram_exec, fast_wake, in_isr,
    output cur_prio, wake_prio, wake_en, rst_en, clk_gate,
    input mode, core_halt, wake
  );
  modport pmc (
    input sleep_req, deep_sleep, mode_sel, ram_exec, fast_wake, in_isr,
    input cur_prio, wake_prio, wake_en, rst_en, clk_gate,
    output mode, core_halt, wake
  );
endinterface : pmc_link_if

// File: include/pmc_pkg.sv
package pmc_pkg;
  // wake source indices
  localparam int NUM_WAKE = 7;
  localparam int WK_RTC_ALARM = 0;
  localparam int WK_RTC_FAIL = 1;
  localparam int WK_LPTIMER = 2;
  localparam int WK_SUPPLY_LOW = 3;
  localparam int WK_REG_LOW = 4;
  localparam int WK_CMP0 = 5;
  localparam int WK_PIN = 6;
  // sources that run without the peripheral bus clock
  localparam logic [6:0] PM3_WAKE_MASK = 7'h1F;

  // mode codes reported to software
  localparam logic [3:0] MODE_PM0 = 4'h0;
  localparam logic [3:0] MODE_PM1 = 4'h1;
  localparam logic [3:0] MODE_PM2 = 4'h2;
  localparam logic [3:0] MODE_PM3 = 4'h3;
  localparam logic [3:0] MODE_PM9 = 4'h9;

  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WAKE = 8'h04;
  localparam logic [7:0] OFS_GATE = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;

  // field positions
  localparam int CTRL_DEEP = 0;
  localparam int CTRL_SEL = 1;
  localparam int CTRL_RAM = 2;
  localparam int CTRL_FAST = 3;
  localparam int CTRL_ISR = 4;
  localparam int CTRL_CPRIO = 8;
  localparam int CTRL_WPRIO = 12;
  localparam int PRIO_FIELD_W = 4;
  localparam int WAKE_EN_LSB = 0;
  localparam int RST_EN_LSB = 8;
  localparam int CMD_SLEEP = 0;
  localparam int STAT_MODE = 0;
  localparam int STAT_HALT = 4;
  localparam int STAT_WOKE = 8;

  // reset values
  localparam logic RST_CTRL_BIT = 1'b0;
  localparam logic [3:0] RST_PRIO = 4'h0;
  localparam logic [6:0] RST_WAKE_EN = 7'h00;
  localparam logic [6:0] RST_RST_EN = 7'h00;
  localparam logic RST_GATE_BIT = 1'b1;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_PM2 = 4'h2,
    ST_PM3 = 4'h4,
    ST_PM9 = 4'h8
  } pmc_state_t;
endpackage : pmc_pkg
